// *** hw/ivts_pkg.sv ***
package ivts_pkg;
  // ==========================================================
  // register map (word index on the plain register port)
  localparam int        ADDR_W       = 4;
  localparam int        DATA_W       = 8;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_VECTOR = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_MASK   = 4'h3;

  // control register fields
  localparam int CTRL_TIMER5_EN  = 0;
  localparam int CTRL_REQTICK_EN = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status / mask fields
  localparam int STAT_REQTICK = 0;
  localparam int STAT_ACKED   = 1;
  localparam int STAT_W       = 2;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // restart opcode layout: 11 nnn 111
  localparam logic [1:0] VEC_TOP_BITS = 2'h3;
  localparam logic [2:0] VEC_LOW_BITS = 3'h7;
  localparam int         VEC_IDX_LSB  = 3;
  localparam int         VEC_IDX_MSB  = 5;
  localparam logic [2:0] VEC_IDX_RESET = 3'h0;
  localparam int         VEC_BIT0     = 0;

  // tick timing
  localparam int CLK_MHZ        = 200;
  localparam int TICK_PERIOD_US = 524290;
  localparam int TICK_CYCLES    = TICK_PERIOD_US * CLK_MHZ;
  localparam int TICK_CNT_W     = 27;

  // acknowledge responder states
  typedef enum logic [1:0] {
    ACK_IDLE  = 2'b01,
    ACK_DRIVE = 2'b10
  } ack_state_t;
endpackage

// *** hw/tick_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int CNT_W  = ivts_pkg::TICK_CNT_W,
  parameter int PERIOD = ivts_pkg::TICK_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  output var  logic tick
);
  import ivts_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             tick_r;
  logic             tick_nxt;

  // ==========================================================
  // free-running period counter, one-cycle tick at wrap
  always_comb
  begin
    if (cnt_r == CNT_W'(PERIOD - 1))
    begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
    else
    begin
      cnt_nxt  = cnt_r + 1'b1;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  // tick only ever follows the counter wrapping to zero
  property p_tick_period;
    @(posedge sys_clk) disable iff (reset)
      tick |-> (cnt_r == '0);
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick not aligned to period wrap");
endmodule
`default_nettype wire

// *** hw/interrupt_vector_and_tick_source.sv ***
// Behaviour
// - acknowledge answer is a restart opcode, C7 to FF in steps of eight.
// - even-vector jumper forces bit zero low, giving C6 to FE.
// - forcing bit zero alters only the driven byte; vector register reads odd.
// - real-time tick every 524.29 ms, jumper selects it as interrupt source.
// - tick interrupts need timer5 disabled, request/tick enabled, mask passing.
// - no acknowledge answer while incoming priority grant is low.
// - when answering acknowledge, outgoing priority line is driven low.
`timescale 1ns/100ps
`default_nettype none
module interrupt_vector_and_tick_source #(
  parameter int TICK_PERIOD = ivts_pkg::TICK_CYCLES,
  parameter int TICK_W      = ivts_pkg::TICK_CNT_W
) (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire logic [ivts_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [ivts_pkg::DATA_W-1:0]   regWrData,
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  output var  logic [ivts_pkg::DATA_W-1:0]   regRdData,
  input  wire logic                          evenVectorJumper,
  input  wire logic                          tickSelectJumper,
  input  wire logic                          dataRequest,
  input  wire logic                          intAck,
  input  wire logic                          priorityIn_n,
  output var  logic                          priorityOut_n,
  output var  logic [ivts_pkg::DATA_W-1:0]   vecData,
  output var  logic                          vecDataOe,
  output var  logic                          irq
);
  import ivts_pkg::*;

  logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
  logic [2:0]        vecIdx_r, vecIdx_nxt;
  logic [STAT_W-1:0] status_r, status_nxt;
  logic [STAT_W-1:0] mask_r, mask_nxt;
  logic [DATA_W-1:0] rdData_r, rdData_nxt;
  logic [DATA_W-1:0] vecData_r, vecData_nxt;
  ack_state_t        ackState_r, ackState_nxt;
  logic              tick;
  logic              reqTickSrc;
  logic              tickPath;
  logic [STAT_W-1:0] pendBits;
  logic              pending;
  logic              ackTaken;
  logic [DATA_W-1:0] oddOpcode;

  // ==========================================================
  // tick source
  tick_divider #(
    .CNT_W  (TICK_W),
    .PERIOD (TICK_PERIOD)
  ) u_tick (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick)
  );

  // ==========================================================
  // interrupt sources and gating
  // shared source line: jumper picks tick or disk data request
  assign reqTickSrc = tickSelectJumper ? tick : dataRequest;
  // enable pair gates the shared line, both must be right
  assign tickPath = ctrl_r[CTRL_REQTICK_EN] & ~ctrl_r[CTRL_TIMER5_EN];
  assign pendBits = status_r & mask_r & {1'b1, tickPath};
  assign pending  = |pendBits;
  assign irq      = pending;
  // stored register always holds the odd restart opcode
  assign oddOpcode = {VEC_TOP_BITS, vecIdx_r, VEC_LOW_BITS};
  assign ackTaken  = intAck & priorityIn_n & pending;

  // ==========================================================
  // downstream grant: pass low upstream grant, pull low when we claim
  assign priorityOut_n = priorityIn_n & ~pending;

  // ==========================================================
  // register next values; set beats read-clear in the same cycle
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    vecIdx_nxt = vecIdx_r;
    mask_nxt   = mask_r;
    status_nxt = status_r;
    rdData_nxt = '0;
    if (regWrite)
    begin
      case (regAddr)
        ADDR_CTRL:   ctrl_nxt   = regWrData;
        ADDR_VECTOR: vecIdx_nxt = regWrData[VEC_IDX_MSB:VEC_IDX_LSB];
        ADDR_MASK:   mask_nxt   = regWrData[STAT_W-1:0];
        default:     ;
      endcase
    end
    if (regRead)
    begin
      case (regAddr)
        ADDR_CTRL:   rdData_nxt = ctrl_r;
        ADDR_VECTOR: rdData_nxt = oddOpcode;
        ADDR_STATUS:
        begin
          rdData_nxt = {{(DATA_W-STAT_W){1'b0}}, status_r};
          status_nxt = '0;
        end
        ADDR_MASK:   rdData_nxt = {{(DATA_W-STAT_W){1'b0}}, mask_r};
        default:     rdData_nxt = '0;
      endcase
    end
    if (reqTickSrc)
      status_nxt[STAT_REQTICK] = 1'b1;
    if (ackTaken)
      status_nxt[STAT_ACKED] = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl_r   <= CTRL_RESET;
      vecIdx_r <= VEC_IDX_RESET;
      status_r <= STAT_RESET;
      mask_r   <= MASK_RESET;
      rdData_r <= '0;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      vecIdx_r <= vecIdx_nxt;
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

  // ==========================================================
  // acknowledge responder: drives the byte for one cycle
  always_comb
  begin
    ackState_nxt = ACK_IDLE;
    vecData_nxt  = '0;
    case (ackState_r)
      ACK_IDLE,
      ACK_DRIVE:
      begin
        if (ackTaken)
        begin
          ackState_nxt = ACK_DRIVE;
          vecData_nxt  = oddOpcode;
          // only the bus copy loses bit zero, register untouched
          if (evenVectorJumper)
            vecData_nxt[VEC_BIT0] = 1'b0;
        end
      end
      default:
      begin
        ackState_nxt = ACK_IDLE;
        vecData_nxt  = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ackState_r <= ACK_IDLE;
      vecData_r  <= '0;
    end
    else
    begin
      ackState_r <= ackState_nxt;
      vecData_r  <= vecData_nxt;
    end
  end

  assign vecData   = vecData_r;
  assign vecDataOe = (ackState_r == ACK_DRIVE);

  // ==========================================================
  // checks
  property p_opcode_form;
    @(posedge sys_clk) disable iff (reset)
      vecDataOe |-> (vecData[7:6] == VEC_TOP_BITS) && (vecData[2:1] == 2'h3)
                    && (vecData[0] == !$past(evenVectorJumper));
  endproperty
  a_opcode_form: assert property (p_opcode_form)
    else $error("acknowledge byte not a restart opcode");

  property p_even_vector;
    @(posedge sys_clk) disable iff (reset)
      (ackTaken && evenVectorJumper) |=> vecDataOe && !vecData[0];
  endproperty
  a_even_vector: assert property (p_even_vector)
    else $error("even jumper did not clear bit zero");

  property p_reg_stays_odd;
    @(posedge sys_clk) disable iff (reset)
      (regRead && regAddr == ADDR_VECTOR) |=> regRdData[0] && regRdData[7:6] == VEC_TOP_BITS;
  endproperty
  a_reg_stays_odd: assert property (p_reg_stays_odd)
    else $error("vector register read not odd opcode");

  property p_source_sets;
    @(posedge sys_clk) disable iff (reset)
      (tickSelectJumper && tick) |=> status_r[STAT_REQTICK];
  endproperty
  a_source_sets: assert property (p_source_sets)
    else $error("tick did not set status");

  property p_tick_gate;
    @(posedge sys_clk) disable iff (reset)
      (irq && !(status_r[STAT_ACKED] && mask_r[STAT_ACKED]))
        |-> ctrl_r[CTRL_REQTICK_EN] && !ctrl_r[CTRL_TIMER5_EN] && mask_r[STAT_REQTICK];
  endproperty
  a_tick_gate: assert property (p_tick_gate)
    else $error("tick interrupt without enables");

  property p_no_grant;
    @(posedge sys_clk) disable iff (reset)
      !priorityIn_n |=> !vecDataOe;
  endproperty
  a_no_grant: assert property (p_no_grant)
    else $error("answered without priority grant");

  property p_claim_chain;
    @(posedge sys_clk) disable iff (reset)
      ackTaken |-> !priorityOut_n ##1 vecDataOe;
  endproperty
  a_claim_chain: assert property (p_claim_chain)
    else $error("claim did not pull priority out low");

  property p_drive_cause;
    @(posedge sys_clk) disable iff (reset)
      vecDataOe |-> $past(intAck) && $past(pending) && $past(priorityIn_n);
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("vector driven without pending acknowledge");

  c_ack_odd:  cover property (@(posedge sys_clk) vecDataOe && vecData[0]);
  c_ack_even: cover property (@(posedge sys_clk) vecDataOe && !vecData[0]);
  c_blocked:  cover property (@(posedge sys_clk) intAck && pending && !priorityIn_n);
  c_tick_irq: cover property (@(posedge sys_clk) tickSelectJumper && tick ##1 irq);
endmodule
`default_nettype wire

// *** bench/ack_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// host side issuing acknowledge cycles
module ack_host (
  input  wire logic [ivts_pkg::DATA_W-1:0] vecData,
  input  wire logic                        vecDataOe,
  input  wire logic                        sys_clk,
  output var  logic                        intAck
);
  import ivts_pkg::*;
  initial intAck = 1'b0;
  // one acknowledge, byte taken in the cycle after the edge
  // host uses vector-style handling, so even bytes are fine here
  task automatic ack(output logic seen, output logic [DATA_W-1:0] val);
    @(posedge sys_clk);
    intAck <= 1'b1;
    @(posedge sys_clk);
    intAck <= 1'b0;
    #1;
    seen = vecDataOe;
    val  = vecData;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
// ==========================================
// bench top
module tb_top;
  import ivts_pkg::*;
  logic              sys_clk, reset, regWrite, regRead, evenJ, tickJ;
  logic              dataRequest, priorityIn_n, priorityOut_n, vecDataOe, irq, intAck, seen;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, vecData, v;
  int                n_errors = 0;
  int                checks = 0;
  int                cyc = 0;
  int                c1;

  // short tick period keeps the run brief
  interrupt_vector_and_tick_source #(.TICK_PERIOD(16), .TICK_W(27)) dut (
    .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .evenVectorJumper(evenJ), .tickSelectJumper(tickJ), .dataRequest(dataRequest),
    .intAck(intAck), .priorityIn_n(priorityIn_n), .priorityOut_n(priorityOut_n),
    .vecData(vecData), .vecDataOe(vecDataOe), .irq(irq));
  ack_host host (.vecData(vecData), .vecDataOe(vecDataOe), .sys_clk(sys_clk), .intAck(intAck));

  // clock and cycle count
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ==========================================
  // bus and helper tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1; regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic raise();
    @(posedge sys_clk);
    dataRequest <= 1'b1;
    @(posedge sys_clk);
    dataRequest <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // bounded wait for irq; running out ends the run
  task automatic wait_irq();
    for (int k = 0; k <= 40 && irq !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
      if (k == 40) begin n_errors++; test_done(); end
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    `CHK(irq, 1'b0)
    `CHK(vecDataOe, 1'b0)
    `CHK(priorityOut_n, 1'b1)
    wr(4'hF, 8'hA5);
    rd(4'hF, v); `CHK(v, 8'h00)
    rd(ADDR_STATUS, v); `CHK(v, 8'h00)
    $display("test reset done");
  endtask
  // vector register always reads back odd, jumper or not
  task automatic t_vector();
    for (int e = 0; e < 2; e++)
      for (int i = 0; i < 8; i++) begin
        @(posedge sys_clk);
        evenJ <= e[0];
        wr(ADDR_VECTOR, {2'h0, i[2:0], 3'h0});
        rd(ADDR_VECTOR, v); `CHK(v, {2'h3, i[2:0], 3'h7})
      end
    $display("test vector done");
  endtask
  // every vector with both jumper settings
  task automatic t_ack();
    wr(ADDR_CTRL, 8'h02); wr(ADDR_MASK, 8'h01);
    for (int e = 0; e < 2; e++)
      for (int i = 0; i < 8; i++) begin
        @(posedge sys_clk);
        evenJ <= e[0];
        wr(ADDR_VECTOR, {2'h0, i[2:0], 3'h0});
        raise();
        `CHK(priorityOut_n, 1'b0)
        host.ack(seen, v);
        `CHK(seen, 1'b1)
        `CHK(v, {2'h3, i[2:0], 2'h3, ~e[0]})
        rd(ADDR_STATUS, v); `CHK(v, 8'h03)
        `CHK(irq, 1'b0)
      end
    $display("test ack done");
  endtask
  // blocked by upstream grant, and no answer without a pending interrupt
  task automatic t_refuse();
    raise();
    @(posedge sys_clk);
    priorityIn_n <= 1'b0;
    host.ack(seen, v); `CHK(seen, 1'b0)
    `CHK(priorityOut_n, 1'b0)
    @(posedge sys_clk);
    priorityIn_n <= 1'b1;
    // a refused acknowledge must not mark the request as served
    rd(ADDR_STATUS, v); `CHK(v, 8'h01)
    host.ack(seen, v); `CHK(seen, 1'b0)
    `CHK(priorityOut_n, 1'b1)
    $display("test refuse done");
  endtask
  task automatic t_gate();
    raise();
    wr(ADDR_CTRL, 8'h03); `CHK(irq, 1'b0)
    wr(ADDR_CTRL, 8'h02); `CHK(irq, 1'b1)
    wr(ADDR_MASK, 8'h00); `CHK(irq, 1'b0)
    wr(ADDR_MASK, 8'h01);
    // served-acknowledge bit raises irq on its own mask bit
    host.ack(seen, v); `CHK(seen, 1'b1)
    wr(ADDR_MASK, 8'h02); `CHK(irq, 1'b1)
    rd(ADDR_CTRL, v); `CHK(v, 8'h02)
    rd(ADDR_MASK, v); `CHK(v, 8'h02)
    rd(ADDR_STATUS, v); `CHK(v, 8'h03)
    `CHK(irq, 1'b0)
    wr(ADDR_MASK, 8'h01);
    $display("test gate done");
  endtask
  // tick through the jumper, spacing of two ticks
  task automatic t_tick();
    @(posedge sys_clk);
    tickJ <= 1'b1;
    rd(ADDR_STATUS, v);
    wait_irq();
    c1 = cyc;
    rd(ADDR_STATUS, v); `CHK(v[0], 1'b1)
    wait_irq();
    `CHK(cyc - c1, 16)
    $display("test tick done");
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    sys_clk = 1'b0; reset = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = '0;
    regWrData = '0; evenJ = 1'b0; tickJ = 1'b0; dataRequest = 1'b0; priorityIn_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_reset(); t_vector(); t_ack(); t_refuse(); t_gate(); t_tick();
    test_done();
  end
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
